//--- src/ecl_params.svh
// Timing counts and field constants for the edge-count LED current control block
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH
`define ECL_CLK_HZ 20000000
`define ECL_LAT_US 500
`define ECL_OFF_US 500
`define ECL_PWM_OFF_US 1000
`define ECL_PWM_ON_NS 2000
`define ECL_LAT_CYC ((`ECL_LAT_US * (`ECL_CLK_HZ / 1000000)))
`define ECL_OFF_CYC ((`ECL_OFF_US * (`ECL_CLK_HZ / 1000000)))
`define ECL_PWM_OFF_CYC ((`ECL_PWM_OFF_US * (`ECL_CLK_HZ / 1000000)))
`define ECL_PWM_ON_CYC ((`ECL_PWM_ON_NS * (`ECL_CLK_HZ / 1000000) + 999) / 1000)
`define ECL_STEP_W 5
`define ECL_CODE_OFF 5'h00
`define ECL_CODE_MAX 5'h01
`define ECL_CNT_W 16
`endif

//--- src/ecl_pkg.sv
// Types shared by the edge-count LED current control block
package ecl_pkg;
  typedef enum logic [1:0] {
    ECL_V16,
    ECL_V8,
    ECL_V4,
    ECL_VPWM
  } ecl_variant_t;
endpackage

//--- src/ecl_sync.sv
// Three-stage input synchroniser with second/third agreement filter
`timescale 1ns/10ps
module ecl_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Stage one feeds only stage two
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level changes only once two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule

//--- src/ecl_core.sv
// Edge-count and pulse-width control logic for a three-channel LED sink driver
`timescale 1ns/10ps
`include "ecl_params.svh"

// Overview of operation
// RQ1 - Serial variants count rising edges; edge count equals step code.
// RQ2 - From shutdown, first rising edge powers up at full-scale step.
// RQ3 - 16-step variant: each further edge lowers current one step.
// RQ4 - 8-step variant uses codes 1 to 8.
// RQ5 - 4-step variant uses codes 1 to 4.
// RQ6 - Line high for latch timeout applies counted step to sinks.
// RQ7 - Line low beyond off timeout enters shutdown, clears step to zero.
// RQ8 - Edges up to 1 MHz are accepted and counted.
// RQ9 - Serial variants leave doubling mode once supply is sufficient.
// RQ10 - Pulse-width variant latches doubling mode once entered.
// RQ11 - Pulse-width line low 1 ms clears latched doubling mode.
// RQ12 - Pulse-width line low 1 ms enters low-power shutdown.
// RQ13 - Pulse-width line enables device and sets brightness, no counting.
// RQ14 - Line level gates sink conduction so average follows duty.
// RQ15 - Host keeps burst low pulses between 0.3 and 75 us.
// RQ16 - Host keeps burst high intervals at most 75 us.
// RQ17 - Host drives pulse-width signal at 50 kHz or less.
// RQ18 - Sinks turn on about 2 us after pulse-width line rises.
// RQ19 - Edges past the last step hold the minimum-current code.
// RQ20 - One latched step code drives all three sink channels.
module ecl_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input ecl_pkg::ecl_variant_t variant,
  input wire logic en_line,
  input wire logic supply_low,
  output logic [`ECL_STEP_W-1:0] led_sink_outputs [3],
  output logic [2:0] sink_gate,
  output logic active,
  output logic pump_2x
);
  import ecl_pkg::*;

  logic en_lvl;
  logic en_prev_r;
  logic rise;
  logic [`ECL_CNT_W-1:0] hi_cnt_r;
  logic [`ECL_CNT_W-1:0] lo_cnt_r;
  logic [`ECL_CNT_W-1:0] lo_lim;
  logic [`ECL_STEP_W-1:0] count_r;
  logic [`ECL_STEP_W-1:0] count_nxt;
  logic [`ECL_STEP_W-1:0] step_r;
  logic [`ECL_STEP_W-1:0] last_code;
  logic latched_r;
  logic on_r;
  logic gate_r;
  logic [`ECL_CNT_W-1:0] on_dly_r;
  logic is_pwm;
  logic lo_expired;
  logic supply_lvl;
  logic [`ECL_STEP_W-1:0] shared_code;
  logic shared_gate;

  localparam logic [`ECL_CNT_W-1:0] LAT_CYC = `ECL_CNT_W'(`ECL_LAT_CYC);
  localparam logic [`ECL_CNT_W-1:0] OFF_CYC = `ECL_CNT_W'(`ECL_OFF_CYC);
  localparam logic [`ECL_CNT_W-1:0] PWM_OFF_CYC = `ECL_CNT_W'(`ECL_PWM_OFF_CYC);
  localparam logic [`ECL_CNT_W-1:0] PWM_ON_CYC = `ECL_CNT_W'(`ECL_PWM_ON_CYC);

  // Last valid code of each serial variant
  function automatic logic [`ECL_STEP_W-1:0] max_code(input ecl_variant_t v);
    unique case (v)
      ECL_V16: max_code = 5'h10; // see RQ3
      ECL_V8: max_code = 5'h08; // see RQ4
      ECL_V4: max_code = 5'h04; // see RQ5
      ECL_VPWM: max_code = `ECL_CODE_MAX;
    endcase
  endfunction

  // A zero code means the sinks are off and the block sits in shutdown
  function automatic logic code_on(input logic [`ECL_STEP_W-1:0] c);
    code_on = (c != `ECL_CODE_OFF);
  endfunction

  // Pin is asynchronous, so it goes through the filter
  ecl_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(en_line),
    .level_out(en_lvl)
  );

  // The supply indication comes from an analog comparator, so it is filtered too
  ecl_sync u_sync_supply (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(supply_low),
    .level_out(supply_lvl)
  );

  assign is_pwm = (variant == ECL_VPWM);
  assign last_code = max_code(variant);
  assign rise = en_lvl & ~en_prev_r; // see RQ8
  assign lo_lim = is_pwm ? PWM_OFF_CYC : OFF_CYC;
  assign lo_expired = (lo_cnt_r >= lo_lim);

  // Edge detector on the filtered level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= en_lvl;
    end
  end

  // Time spent high since the filtered level rose; stops at the latch count
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !en_lvl) begin
      hi_cnt_r <= '0;
    end else if (hi_cnt_r != LAT_CYC) begin
      hi_cnt_r <= hi_cnt_r + 1'b1;
    end
  end

  // Time spent low; it saturates so a parked-low pin never wraps into a burst
  always_ff @(posedge ref_clk) begin
    if (!rst_n || en_lvl) begin
      lo_cnt_r <= '0;
    end else if (!lo_expired) begin
      lo_cnt_r <= lo_cnt_r + 1'b1;
    end
  end

  // Burst counter saturates at the minimum-current code
  always_comb begin
    count_nxt = count_r;
    if (rise) begin
      if (latched_r || !code_on(count_r)) begin
        count_nxt = code_on(step_r) ? step_r : `ECL_CODE_MAX; // see RQ2
        if (code_on(step_r) && step_r < last_code) begin
          count_nxt = step_r + 1'b1; // see RQ3
        end
      end else if (count_r < last_code) begin
        count_nxt = count_r + 1'b1; // see RQ1
      end // see RQ19
    end
  end

  // Serial step tracking; a new burst continues from the applied step
  always_ff @(posedge ref_clk) begin
    if (!rst_n || is_pwm) begin
      count_r <= `ECL_CODE_OFF;
      step_r <= `ECL_CODE_OFF;
      latched_r <= 1'b1;
    end else if (!en_lvl && lo_expired) begin
      count_r <= `ECL_CODE_OFF; // see RQ7
      step_r <= `ECL_CODE_OFF;
      latched_r <= 1'b1;
    end else if (rise) begin
      count_r <= count_nxt;
      latched_r <= 1'b0;
    end else if (en_lvl && !latched_r && hi_cnt_r == LAT_CYC) begin
      step_r <= count_r; // see RQ6
      latched_r <= 1'b1;
    end
  end

  // Pulse-width enable: any high level powers up, a long low shuts down
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !is_pwm) begin
      on_r <= 1'b0;
    end else if (en_lvl) begin
      on_r <= 1'b1; // see RQ13
    end else if (lo_expired) begin
      on_r <= 1'b0; // see RQ12
    end
  end

  // Turn-on delay restarts at every rise, so very short high pulses never reach the sinks
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !is_pwm) begin
      on_dly_r <= '0;
      gate_r <= 1'b0;
    end else begin
      on_dly_r <= !en_lvl ? '0 : (on_dly_r == PWM_ON_CYC) ? on_dly_r : on_dly_r + 1'b1;
      gate_r <= en_lvl && (on_dly_r == PWM_ON_CYC); // see RQ18
    end
  end

  // Doubling mode: serial variants follow supply, pulse-width latches it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pump_2x <= 1'b0;
    end else if (is_pwm) begin
      if (!on_r) begin
        pump_2x <= 1'b0; // see RQ11
      end else if (supply_lvl) begin
        pump_2x <= 1'b1; // see RQ10
      end
    end else begin
      pump_2x <= supply_lvl && code_on(step_r); // see RQ9
    end
  end

  // One code and one gate are shared, so the three channels cannot drift apart
  assign shared_code = is_pwm ? (on_r ? `ECL_CODE_MAX : `ECL_CODE_OFF) : step_r;
  assign shared_gate = is_pwm ? gate_r : code_on(step_r);

  // Registered copies for each sink
  generate
    for (genvar i = 0; i < 3; i++) begin : g_ch
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          led_sink_outputs[i] <= `ECL_CODE_OFF;
          sink_gate[i] <= 1'b0;
        end else begin
          led_sink_outputs[i] <= shared_code; // see RQ20
          sink_gate[i] <= shared_gate; // see RQ14
        end
      end
    end
  endgenerate

  // Device powered indication
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else begin
      active <= is_pwm ? on_r : code_on(step_r);
    end
  end
endmodule

//--- test/ecl_core_checker.sv
// Assertions on the ports of the LED control core
`timescale 1ns/10ps
`include "ecl_params.svh"
module ecl_core_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input ecl_pkg::ecl_variant_t variant,
  input wire logic en_line,
  input wire logic supply_low,
  input wire logic [`ECL_STEP_W-1:0] led_sink_outputs [3],
  input wire logic [2:0] sink_gate,
  input wire logic active,
  input wire logic pump_2x
);
  import ecl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Short names for the channel codes and the last code of each serial variant
  wire logic [4:0] c0 = led_sink_outputs[0];
  wire logic [4:0] c1 = led_sink_outputs[1];
  wire logic [4:0] c2 = led_sink_outputs[2];
  wire logic pw = (variant == ECL_VPWM);
  wire logic [4:0] lim = (variant == ECL_V16) ? 5'h10 : (variant == ECL_V8) ? 5'h08 : 5'h04;
  a_chan_same: assert property (c0 == c1 && c1 == c2)
    else $error("channel codes differ");
  a_gate_all: assert property (sink_gate == 3'h0 || sink_gate == 3'h7)
    else $error("sink gates split");
  a_step_range: assert property (pw || c0 <= lim)
    else $error("code beyond last step");
  a_off_clear: assert property ($fell(active) |-> c0 == 5'h00)
    else $error("shutdown kept a code");
  a_latch_high: assert property ($changed(c0) && c0 != 5'h00 && !pw |->
    $past(en_line, 4))
    else $error("code applied while pin low");
  a_serial_on: assert property (!pw && active && $past(active) |-> sink_gate == 3'h7)
    else $error("serial sinks off while active");
  a_serial_1x: assert property ((!pw && !supply_low) [*5] |=> !pump_2x)
    else $error("serial 2x held with enough supply");
  a_pwm_2x_hold: assert property (pw && pump_2x && active |=> pump_2x || !active)
    else $error("latched 2x dropped");
  a_pwm_gate_off: assert property ((pw && !en_line) [*8] |-> sink_gate == 3'h0)
    else $error("gate on with pin low");
  a_pwm_on_late: assert property (pw && $rose(sink_gate[0]) |-> $past(en_line, 30))
    else $error("gate on too early");
endmodule
bind ecl_core ecl_core_checker i_chk (.ref_clk, .rst_n, .variant, .en_line, .supply_low,
  .led_sink_outputs, .sink_gate, .active, .pump_2x);

//--- test/ecl_host.sv
// Host model driving the control pin with bursts of rising edges
`timescale 1ns/10ps
module ecl_host (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [4:0] n,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  output logic en_line,
  output logic busy
);
  // A count of zero parks the pin low; after a burst the pin stays high
  initial begin
    en_line = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy = 1'b1;
        #2 en_line = 1'b0;
        for (int i = 0; i < n; i++) begin
          repeat (lo) @(posedge ref_clk);
          #2 en_line = 1'b1;
          repeat (hi) @(posedge ref_clk);
          if (i < n - 1) #2 en_line = 1'b0;
        end
        busy = 1'b0;
      end
    end
  end
endmodule

//--- test/test_ecl_core.sv
// Self-checking testbench for the LED control core
`timescale 1ns/10ps
`include "ecl_params.svh"
module test_ecl_core;
  import ecl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n, supply_low, en_line, go, busy, active, pump_2x;
  ecl_variant_t variant;
  logic [4:0] n, e, prev = 5'h00;
  logic [7:0] lo, hi;
  logic [`ECL_STEP_W-1:0] leds [3];
  logic [2:0] sink_gate;
  logic [4:0] exp_q [$];
  int seed, mismatches, samples_checked, k;
  always #25 ref_clk = ~ref_clk;
  ecl_core i_dut (.ref_clk, .rst_n, .variant, .en_line, .supply_low,
    .led_sink_outputs(leds), .sink_gate, .active, .pump_2x);
  ecl_host i_host (.ref_clk, .go, .n, .lo, .hi, .en_line, .busy);
  task automatic check(logic ok, string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One host burst, then wait until every noted code has shown up
  task automatic burst(int cnt, int l, int h);
    int t;
    n = 5'(cnt);
    lo = 8'(l);
    hi = 8'(h);
    go = 1'b1;
    @(posedge ref_clk);
    #2 go = 1'b0;
    for (t = 0; busy && t < 4000; t++) @(posedge ref_clk) #2;
    for (t = 0; exp_q.size() > 0 && t < 25000; t++) @(posedge ref_clk) #2;
    if (busy || exp_q.size() > 0) begin
      check(1'b0, "timeout");
      wrap_up();
    end
    $display("burst of %0d done", cnt);
  endtask
  // Each change of the shared code takes the oldest note; negedge keeps clear of updates
  always @(negedge ref_clk) begin
    if (rst_n && leds[0] !== prev) begin
      prev = leds[0];
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h1f;
      check(leds[0] === e && leds[1] === e && leds[2] === e, "code");
    end
  end
  initial begin
    seed = 82978;
    rst_n = 1'b0;
    supply_low = 1'b0;
    go = 1'b0;
    variant = ECL_V16;
    repeat (5) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    k = 1 + $unsigned($random(seed)) % 8;
    exp_q.push_back(5'(k));
    burst(k, 6 + $unsigned($random(seed)) % 32, 14);
    check(sink_gate === 3'h7 && active === 1'b1, "sinks off");
    supply_low = 1'b1;
    repeat (8) @(posedge ref_clk);
    #2 check(pump_2x === 1'b1, "no 2x");
    supply_low = 1'b0;
    repeat (8) @(posedge ref_clk);
    #2 check(pump_2x === 1'b0, "2x kept");
    exp_q.push_back(5'(k + 2));
    burst(2, 10, 10);
    exp_q.push_back(5'h00);
    burst(0, 10, 10);
    for (int v = 1; v < 3; v++) begin
      variant = ecl_variant_t'(v);
      exp_q.push_back(5'(8 >> (v - 1)));
      burst(9, 6, 14);
      exp_q.push_back(5'h00);
      burst(0, 10, 10);
    end
    variant = ECL_VPWM;
    exp_q.push_back(5'h01);
    burst(1, 10, 10);
    burst(3, 150, 250);
    check(sink_gate === 3'h7, "gate off");
    supply_low = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2 supply_low = 1'b0;
    repeat (5) @(posedge ref_clk);
    #2 check(pump_2x === 1'b1, "2x dropped");
    exp_q.push_back(5'h00);
    burst(0, 10, 10);
    check(pump_2x === 1'b0 && active === 1'b0, "not off");
    wrap_up();
  end
endmodule
